// *** mrc_pkg.sv ***
// Package for the receive control block: register map, field layout, limits and types
package mrc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] MRC_CTRL_OFF = 12'h104;
    localparam logic [11:0] MRC_IRQ_STAT_OFF = 12'h140;
    localparam logic [11:0] MRC_IRQ_MASK_OFF = 12'h144;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register field positions
    localparam int MRC_EN_BIT = 0;
    localparam int MRC_DIS_BIT = 1;
    localparam int MRC_VLAN_BIT = 2;
    localparam int MRC_STRIP_BIT = 4;
    localparam int MRC_TRUNC_BIT = 5;
    localparam int MRC_MAX_LSB = 16;
    localparam int MRC_MAX_MSB = 29;

    // Control register reset values
    localparam logic [13:0] MRC_MAX_RST = 14'h05ee;
    localparam logic MRC_TRUNC_RST = 1'b1;
    localparam logic MRC_STRIP_RST = 1'b0;
    localparam logic MRC_VLAN_RST = 1'b0;
    localparam logic MRC_EN_RST = 1'b0;
    localparam logic MRC_DIS_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask layout
    localparam int MRC_IRQ_W = 3;
    localparam int MRC_IRQ_FRAME_BIT = 0;
    localparam int MRC_IRQ_OVER_BIT = 1;
    localparam int MRC_IRQ_DIS_BIT = 2;
    localparam logic [2:0] MRC_IRQ_RST = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame length figures, in bytes, and VLAN tag identifiers
    localparam logic [14:0] MRC_WDOG_BYTES = 15'h2c00;
    localparam logic [14:0] MRC_WDOG_CUT = MRC_WDOG_BYTES + 15'h0001;
    localparam logic [14:0] MRC_TAG_BYTES = 15'h0004;
    localparam logic [2:0] MRC_FCS_BYTES = 3'h4;
    localparam logic [14:0] MRC_TAG1_POS = 15'h000e;
    localparam logic [14:0] MRC_TAG2_POS = 15'h0012;
    localparam logic [15:0] MRC_TPID_C = 16'h8100;
    localparam logic [15:0] MRC_TPID_S = 16'h88a8;

    // AXI response codes
    localparam logic [1:0] MRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MRC_RESP_DECERR = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mrc_byte_t;

    typedef struct packed {
        logic [13:0] len;
        logic oversize;
        logic watchdog;
        logic [1:0] tags;
    } mrc_rx_status_t;

    typedef enum logic [1:0] {MRC_IDLE, MRC_FRAME, MRC_DISCARD} mrc_state_t;

endpackage : mrc_pkg

// *** mrc_rx_ctrl.sv ***
// Receive control of the MAC: size limits, truncation, FCS strip, enable and disable
//
// How it works
// R01: A 14-bit maximum length resetting to 1518 flags any frame longer than it plus the VLAN allowance of R08 as aborted.
// R02: A watchdog always cuts and aborts any frame that runs beyond 11264 bytes.
// R03: Software keeps the size, truncation, strip and VLAN controls still while enabled.
// R04: With truncation select clear and the limit below 11264, a long frame is cut at limit plus one with that length.
// R05: With truncation select set (reset), a long frame is cut at 11265 with watchdog flagged.
// R06: With strip set the last 4 bytes of every frame are withheld; the bit resets to zero.
// R07: With VLAN enforcement clear every frame above the maximum is aborted.
// R08: With VLAN enforcement set the limit grows by 4 per VLAN tag, for up to two tags.
// R09: Frames are accepted only while the receiver enable bit is set; it resets to zero.
// R10: Clearing enable mid-frame lets the frame finish before the receiver stops.
// R11: A sticky disabled flag is set when the stop after a 1-to-0 enable change completes.
// R12: Writing one clears the disabled flag, and reserved bits read zero and ignore writes.
module mrc_rx_ctrl
    import mrc_pkg::*;
(
    // Clock, reset, clock enable
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Bytes from the PHY, valid high across the whole frame
    input wire mrc_byte_t phy_rx_in,
    // Bytes and status towards the fifo_controller
    output mrc_byte_t fifo_rx_out,
    output logic fifo_end_out,
    output mrc_rx_status_t receive_status_word_out,
    // Interrupt
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [13:0] max_len_r;
    logic truncation_length_select_r;
    logic strip_r;
    logic vlan_size_enforce_r;
    logic receiver_enable_r;
    logic rx_disabled_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_wr;
    mrc_state_t st_r;
    mrc_state_t st_nxt;
    logic rx_on_r;
    logic prev_valid_r;
    logic [14:0] cnt_r;
    logic [14:0] cnt_nxt;
    logic [7:0] last_byte_r;
    logic [1:0] tags_r;
    logic [1:0] tags_nxt;
    logic [14:0] limit;
    logic [14:0] cut_at;
    logic take;
    logic frame_end;
    logic cut_now;
    logic [7:0] dly_r [0:3];
    logic [2:0] held_r;
    mrc_byte_t out_r;
    logic end_r;
    mrc_rx_status_t stat_r;
    logic dis_event;
    logic [2:0] irq_event;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic mrc_is_tpid(input logic [7:0] hi, input logic [7:0] lo);
        mrc_is_tpid = ({hi, lo} == MRC_TPID_C) || ({hi, lo} == MRC_TPID_S);
    endfunction : mrc_is_tpid

    function automatic logic [31:0] mrc_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        mrc_merge = res;
    endfunction : mrc_merge

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data taken in either order, one write at a time
    assign s_axi_awready_out = ce_in && !aw_held_r && !bvalid_r;
    assign s_axi_wready_out = ce_in && !w_held_r && !bvalid_r;
    assign s_axi_arready_out = ce_in && !rvalid_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;
    assign do_write = ce_in && aw_held_r && w_held_r && !bvalid_r;
    assign wr_addr = awaddr_r;
    assign wr_data = wdata_r;
    assign wr_strb = wstrb_r;
    // Control word after byte strobes are applied
    assign ctrl_wr = mrc_merge(ctrl_word, wr_data, wr_strb);

    // Write channel capture and response
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= MRC_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr_in[11:2], 2'h0};
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                if (wr_addr == MRC_CTRL_OFF || wr_addr == MRC_IRQ_STAT_OFF ||
                    wr_addr == MRC_IRQ_MASK_OFF)
                    bresp_r <= MRC_RESP_OKAY;
                else
                    bresp_r <= MRC_RESP_DECERR;
            end
            else if (bvalid_r && s_axi_bready_in)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Control word as read back, reserved bits zero
    always_comb
    begin
        ctrl_word = 32'h00000000;
        ctrl_word[MRC_MAX_MSB:MRC_MAX_LSB] = max_len_r;
        ctrl_word[MRC_TRUNC_BIT] = truncation_length_select_r;
        ctrl_word[MRC_STRIP_BIT] = strip_r;
        ctrl_word[MRC_VLAN_BIT] = vlan_size_enforce_r;
        ctrl_word[MRC_DIS_BIT] = rx_disabled_r;
        ctrl_word[MRC_EN_BIT] = receiver_enable_r;
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= MRC_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (s_axi_arvalid_in && s_axi_arready_out)
            begin
                rvalid_r <= 1'b1;
                rresp_r <= MRC_RESP_OKAY;
                if ({s_axi_araddr_in[11:2], 2'h0} == MRC_CTRL_OFF)
                    rdata_r <= ctrl_word; // [R12]
                else if ({s_axi_araddr_in[11:2], 2'h0} == MRC_IRQ_STAT_OFF)
                    rdata_r <= {29'h00000000, irq_stat_r};
                else if ({s_axi_araddr_in[11:2], 2'h0} == MRC_IRQ_MASK_OFF)
                    rdata_r <= {29'h00000000, irq_mask_r};
                else
                begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= MRC_RESP_DECERR;
                end
            end
            else if (rvalid_r && s_axi_rready_in)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register; reserved bits are never stored
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            max_len_r <= MRC_MAX_RST; // [R01]
            truncation_length_select_r <= MRC_TRUNC_RST; // [R05]
            strip_r <= MRC_STRIP_RST; // [R06]
            vlan_size_enforce_r <= MRC_VLAN_RST;
            receiver_enable_r <= MRC_EN_RST; // [R09]
        end
        else if (ce_in && do_write && wr_addr == MRC_CTRL_OFF)
        begin
            max_len_r <= ctrl_wr[MRC_MAX_MSB:MRC_MAX_LSB]; // [R12]
            truncation_length_select_r <= ctrl_wr[MRC_TRUNC_BIT];
            strip_r <= ctrl_wr[MRC_STRIP_BIT];
            vlan_size_enforce_r <= ctrl_wr[MRC_VLAN_BIT];
            receiver_enable_r <= ctrl_wr[MRC_EN_BIT];
        end
    end

    // Sticky disabled flag: hardware set wins over a write-one clear
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            rx_disabled_r <= MRC_DIS_RST;
        else if (ce_in)
        begin
            if (dis_event)
                rx_disabled_r <= 1'b1; // [R11]
            else if (do_write && wr_addr == MRC_CTRL_OFF && wr_strb[0] && wr_data[MRC_DIS_BIT])
                rx_disabled_r <= 1'b0; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, set wins over write-one clear, and mask
    assign irq_event = {dis_event, end_r && stat_r.oversize, end_r};
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            irq_stat_r <= MRC_IRQ_RST;
            irq_mask_r <= MRC_IRQ_RST;
        end
        else if (ce_in)
        begin
            if (do_write && wr_addr == MRC_IRQ_STAT_OFF && wr_strb[0])
                irq_stat_r <= (irq_stat_r & ~wr_data[2:0]) | irq_event;
            else
                irq_stat_r <= irq_stat_r | irq_event;
            if (do_write && wr_addr == MRC_IRQ_MASK_OFF && wr_strb[0])
                irq_mask_r <= wr_data[2:0];
        end
    end
    assign irq_out = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////////
    // Size limit and cut point for the frame in progress
    always_comb
    begin
        limit = {1'b0, max_len_r}; // [R07]
        if (vlan_size_enforce_r)
            limit = {1'b0, max_len_r} + (MRC_TAG_BYTES * {13'h0000, tags_r}); // [R08]
        if (truncation_length_select_r || (limit >= MRC_WDOG_BYTES))
            cut_at = MRC_WDOG_CUT; // [R02] [R05]
        else
            cut_at = limit + 15'h0001; // [R04]
    end

    // Frame sequencing: a frame is a run of valid bytes from the PHY
    assign take = phy_rx_in.valid && ((st_r == MRC_IDLE && !prev_valid_r && rx_on_r) ||
                                      st_r == MRC_FRAME); // [R09]
    assign cnt_nxt = take ? cnt_r + 15'h0001 : cnt_r;
    assign cut_now = take && (cnt_nxt == cut_at); // [R02] [R04] [R05]
    assign frame_end = (st_r == MRC_FRAME && !phy_rx_in.valid) || cut_now;
    assign dis_event = ce_in && rx_on_r && !receiver_enable_r && st_nxt == MRC_IDLE &&
                       !take; // [R10] [R11]

    // VLAN tag counting from the type fields of the first and second tag
    always_comb
    begin
        tags_nxt = tags_r;
        if (take && cnt_nxt == MRC_TAG1_POS && mrc_is_tpid(last_byte_r, phy_rx_in.data))
            tags_nxt = 2'h1; // [R08]
        else if (take && cnt_nxt == MRC_TAG2_POS && tags_r == 2'h1 &&
                 mrc_is_tpid(last_byte_r, phy_rx_in.data))
            tags_nxt = 2'h2; // [R08]
    end

    // Next state
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            MRC_IDLE:
                if (take)
                    st_nxt = cut_now ? MRC_DISCARD : MRC_FRAME;
            MRC_FRAME:
                if (!phy_rx_in.valid)
                    st_nxt = MRC_IDLE;
                else if (cut_now)
                    st_nxt = MRC_DISCARD; // [R02]
            MRC_DISCARD:
                if (!phy_rx_in.valid)
                    st_nxt = MRC_IDLE;
            default:
                st_nxt = MRC_IDLE;
        endcase
    end

    // State, counters and receiver run flag
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            st_r <= MRC_IDLE;
            rx_on_r <= 1'b0;
            prev_valid_r <= 1'b0;
            cnt_r <= 15'h0000;
            last_byte_r <= 8'h00;
            tags_r <= 2'h0;
        end
        else if (ce_in)
        begin
            st_r <= st_nxt;
            prev_valid_r <= phy_rx_in.valid;
            if (st_nxt == MRC_IDLE && !take)
                rx_on_r <= receiver_enable_r; // [R10]
            if (st_r == MRC_IDLE && !take)
            begin
                cnt_r <= 15'h0000;
                tags_r <= 2'h0;
            end
            else
            begin
                cnt_r <= cnt_nxt;
                tags_r <= tags_nxt;
            end
            if (take)
                last_byte_r <= phy_rx_in.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte path: four-byte delay line withholds the FCS when stripping
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            held_r <= 3'h0;
            out_r <= '0;
            for (int i = 0; i < 4; i++)
                dly_r[i] <= 8'h00;
        end
        else if (ce_in)
        begin
            out_r.valid <= 1'b0;
            if (take)
            begin
                dly_r[0] <= phy_rx_in.data;
                for (int i = 1; i < 4; i++)
                    dly_r[i] <= dly_r[i-1];
                held_r <= (held_r == MRC_FCS_BYTES) ? held_r : held_r + 3'h1;
                if (!strip_r)
                begin
                    out_r.valid <= 1'b1;
                    out_r.data <= phy_rx_in.data;
                end
                else if (held_r == MRC_FCS_BYTES)
                begin
                    out_r.valid <= 1'b1; // [R06]
                    out_r.data <= dly_r[3];
                end
            end
            else if (st_r != MRC_FRAME)
                held_r <= 3'h0;
        end
    end
    assign fifo_rx_out = out_r;

    // Frame status towards the fifo_controller, one pulse per frame
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            end_r <= 1'b0;
            stat_r <= '0;
        end
        else if (ce_in)
        begin
            end_r <= frame_end;
            if (frame_end)
            begin
                stat_r.len <= cnt_nxt[13:0]; // [R04] [R05]
                // A watchdog cut always counts as aborted, even above a large limit
                stat_r.oversize <= (cnt_nxt > limit) ||
                                   (cut_now && cut_at == MRC_WDOG_CUT); // [R01] [R02] [R07] [R08]
                stat_r.watchdog <= cut_now && cut_at == MRC_WDOG_CUT; // [R05]
                stat_r.tags <= tags_nxt;
            end
        end
    end
    assign fifo_end_out = end_r;
    assign receive_status_word_out = stat_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    a_reset_values: assert property ($past(srst_in) |-> ctrl_word == 32'h05ee0020) // [R01]
        else $error("control register reset value wrong");
    a_watchdog_cut: assert property (end_r |-> stat_r.len <= 14'(MRC_WDOG_CUT)) // [R02]
        else $error("frame ran past the watchdog length");
    a_short_cut: assert property (ce_in && cut_now && !truncation_length_select_r &&
        cut_at != MRC_WDOG_CUT |=> end_r && stat_r.oversize && !stat_r.watchdog &&
        stat_r.len == 14'({1'b0, max_len_r} + (vlan_size_enforce_r ? MRC_TAG_BYTES *
        {13'h0000, stat_r.tags} : 15'h0000) + 15'h0001)) // [R04]
        else $error("short truncation length or flags wrong");
    a_long_cut: assert property (end_r && stat_r.watchdog |-> stat_r.oversize &&
        stat_r.len == 14'(MRC_WDOG_CUT)) // [R05]
        else $error("watchdog truncation status wrong");
    a_strip_gap: assert property (ce_in && take && strip_r && held_r < MRC_FCS_BYTES
        |=> !fifo_rx_out.valid) // [R06]
        else $error("byte passed while the FCS window was filling");
    a_plain_limit: assert property (end_r && !vlan_size_enforce_r |->
        stat_r.oversize == (stat_r.len > max_len_r || stat_r.watchdog)) // [R07]
        else $error("oversize flag wrong without VLAN enforcement");
    a_no_accept_off: assert property (!rx_on_r |-> !take) // [R09]
        else $error("byte accepted while receiver stopped");
    a_finish_frame: assert property (st_r == MRC_FRAME && phy_rx_in.valid && ce_in &&
        !cut_now |=> rx_on_r) // [R10]
        else $error("receiver stopped inside a frame");
    a_dis_sticky: assert property (ce_in && dis_event |=> rx_disabled_r && !rx_on_r) // [R11]
        else $error("disabled flag not set after stop");
    a_irq_level: assert property (##1 irq_out == |($past(irq_stat_r | irq_event) & irq_mask_r)
        || $past(do_write) || !$past(ce_in)) // [R11]
        else $error("interrupt output does not follow status and mask");

    c_frame_ok: cover property (end_r && !stat_r.oversize);
    c_wdog_cut: cover property (end_r && stat_r.watchdog);
    c_vlan_two: cover property (end_r && stat_r.tags == 2'h2);
    c_mid_disable: cover property (st_r == MRC_FRAME && !receiver_enable_r ##[1:50] dis_event);

endmodule : mrc_rx_ctrl

// *** mrc_phy_model.sv ***
// Behavioural PHY that delivers received frames as a byte stream
module mrc_phy_model
    import mrc_pkg::*;
(
    // Clock
    input wire logic core_clk_in,
    // Byte stream towards the receive control
    output mrc_byte_t phy_rx_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial phy_rx_out = '{valid: 1'b0, data: 8'h00};

    // Sends len bytes with up to two VLAN tags; idle data shows the inverse
    task automatic send(input int len, input int tags);
        logic [7:0] d;
        for (int i = 0; i < len; i++)
        begin
            d = i[7:0];
            if (tags > 0 && i == 12) d = 8'h81;
            if (tags > 0 && i == 13) d = 8'h00;
            if (tags > 1 && i == 16) d = 8'h88;
            if (tags > 1 && i == 17) d = 8'ha8;
            @(posedge core_clk_in);
            phy_rx_out <= '{valid: 1'b1, data: d};
        end
        @(posedge core_clk_in);
        phy_rx_out <= '{valid: 1'b0, data: ~d};
    endtask : send
endmodule : mrc_phy_model

// *** mrc_tb.sv ***
// Testbench for the receive control: register tasks and frame tests
module tb
    import mrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [31:0] wd = 32'h0, rd;
    logic [3:0] ws = 4'hf;
    logic awr, wr, bv, arr, rv, fend, irq;
    logic [1:0] br, rr, lastb, lastr;
    mrc_byte_t phy, fifo;
    mrc_rx_status_t st;
    int failures = 0, num_checks = 0, nb = 0, ne = 0;
    logic [31:0] v;
    logic [7:0] lb;

    initial forever #2.5 clk = ~clk;

    mrc_phy_model i_phy (.core_clk_in(clk), .phy_rx_out(phy));
    mrc_rx_ctrl i_dut (.core_clk_in(clk), .srst_in(srst), .ce_in(ce),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .phy_rx_in(phy),
        .fifo_rx_out(fifo), .fifo_end_out(fend), .receive_status_word_out(st),
        .irq_out(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // Counts bytes and frame ends passed on
    always @(posedge clk)
    begin
        if (fifo.valid === 1'b1)
        begin
            nb++;
            lb = fifo.data;
        end
        if (fend === 1'b1) ne++;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // AXI4-Lite write; each channel released when taken
    task axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        lastb = br;
        bre <= 1'b0;
    endtask : axw

    // AXI4-Lite read
    task axr(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        d = rd;
        lastr = rr;
        rre <= 1'b0;
    endtask : axr

    // Stops with fields untouched, reconfigures while stopped, then enables
    task cfg(input logic [31:0] c);
        logic [31:0] o;
        axr(MRC_CTRL_OFF, o);
        axw(MRC_CTRL_OFF, o & 32'hfffffffc);
        axw(MRC_CTRL_OFF, c);
        axw(MRC_CTRL_OFF, c | 32'h1);
    endtask : cfg

    // Sends one frame and checks end, status and byte count
    task fr(input int len, input int tg, input logic [17:0] es, input int eb);
        int b0, e0;
        b0 = nb;
        e0 = ne;
        i_phy.send(len, tg);
        repeat (4) @(posedge clk);
        chk(ne - e0, 1, "ends");
        chk(st, es, "status");
        chk(nb - b0, eb, "bytes");
        $display("frame test of %0d bytes done", len);
    endtask : fr

    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        axr(MRC_CTRL_OFF, v);
        chk(v, 32'h05ee0020, "ctrl reset");
        axr(12'h200, v);
        chk(v, 32'h0, "unmapped read");
        chk(lastr, MRC_RESP_DECERR, "unmapped read resp");
        axw(12'h200, 32'hffffffff);
        chk(lastb, MRC_RESP_DECERR, "unmapped write");
        i_phy.send(10, 0);
        repeat (4) @(posedge clk);
        chk(ne, 0, "stopped rx");
        $display("register and stopped tests done");
        cfg(32'h00400000);
        fr(64, 0, {14'h040, 4'b0000}, 64);
        fr(80, 0, {14'h041, 4'b1000}, 65);
        fr(68, 1, {14'h041, 4'b1001}, 65);
        cfg(32'h00400004);
        fr(68, 1, {14'h044, 4'b0001}, 68);
        fr(72, 2, {14'h048, 4'b0010}, 72);
        fr(70, 0, {14'h041, 4'b1000}, 65);
        cfg(32'h00400010);
        fr(20, 0, {14'h014, 4'b0000}, 16);
        chk(lb, 8'h0f, "stripped tail");
        cfg(32'h00400020);
        fr(11300, 0, {14'h2c01, 4'b1100}, 11265);
        cfg(32'h3fff0000);
        fr(11300, 0, {14'h2c01, 4'b1100}, 11265);
        cfg(32'h00400000);
        fork
            fr(40, 0, {14'h028, 4'b0000}, 40);
            begin
                repeat (10) @(posedge clk);
                axw(MRC_CTRL_OFF, 32'h00400000);
            end
        join
        axr(MRC_CTRL_OFF, v);
        chk(v, 32'h00400002, "disabled flag");
        axw(MRC_CTRL_OFF, 32'h00400002);
        chk(lastb, MRC_RESP_OKAY, "mapped write");
        axr(MRC_CTRL_OFF, v);
        chk(v, 32'h00400000, "flag cleared");
        axr(MRC_IRQ_STAT_OFF, v);
        chk(v, 32'h7, "irq status");
        chk(irq, 1'b0, "irq masked");
        axw(MRC_IRQ_MASK_OFF, 32'h4);
        chk(irq, 1'b1, "irq raised");
        axw(MRC_IRQ_STAT_OFF, 32'h7);
        chk(irq, 1'b0, "irq cleared");
        $display("disable and interrupt tests done");
        report_and_stop();
    end
endmodule : tb
